// ---- design/scad_pkg.sv ----
// package for the command, address and mask decode of a dual-bank sdram
// assumes one rising-edge clock shared by every file that imports it
`default_nettype none
package scad_pkg;

  localparam int ADDR_W = 10;
  localparam int ROW_W = 11;
  localparam int DATA_W = 16;
  localparam int LANES = 2;
  localparam int FLAG_POS = 10;
  localparam int COL_TOP_X4 = 9;
  localparam int COL_TOP_X8 = 8;
  localparam int COL_TOP_X16 = 7;
  localparam int READ_MASK_LAT = 2;
  localparam int WRITE_MASK_LAT = 0;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] RESET_OE = 2'h0;
  localparam logic [ROW_W-1:0] RESET_ROW = 11'h000;

  typedef enum logic [1:0] {ORG_X4, ORG_X8, ORG_X16} scad_org_e;

  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
    CMD_PRECHARGE, CMD_BURST_STOP, CMD_MODE_SET, CMD_REFRESH
  } scad_cmd_e;

  // pin levels as sampled at one rising edge
  typedef struct packed {
    logic select_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_en_n;
    logic precharge_flag_bit;
    logic bank_choose;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] mask;
    logic [DATA_W-1:0] data_lines;
  } scad_pins_s;

  localparam int PINS_W = $bits(scad_pins_s);

  function automatic scad_cmd_e scad_decode(input scad_pins_s p);
    logic [2:0] code;
    code = {p.row_strobe_n, p.col_strobe_n, p.write_en_n};
    if (p.select_n) begin
      return CMD_DESELECT;
    end
    unique case (code)
      3'h3: return CMD_ACTIVATE;
      3'h5: return CMD_READ;
      3'h4: return CMD_WRITE;
      3'h2: return CMD_PRECHARGE;
      3'h6: return CMD_BURST_STOP;
      3'h0: return CMD_MODE_SET;
      3'h1: return CMD_REFRESH;
      3'h7: return CMD_NOP;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] scad_col_mask(input scad_org_e org);
    unique case (org)
      ORG_X4: return 10'h3ff;
      ORG_X8: return 10'h1ff;
      ORG_X16: return 10'h0ff;
      default: return 10'h0ff;
    endcase
  endfunction

endpackage
`default_nettype wire

// ---- design/scad_sync.sv ----
// two-flop synchroniser for a bundle of pin levels
// assumes the pins are quasi-static around the sampling edge
`default_nettype none
module scad_sync #(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] async_in,
  input wire logic [W-1:0] reset_val_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [1:0] started_reg;

  // the async reset loads constants only; the idle value is muxed in below
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
      started_reg <= 2'h0;
    end else begin
      started_reg <= {started_reg[0], 1'b1};
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  // idle value shows until the second flop holds a real pin sample
  assign sync_out = started_reg[1] ? sync_reg : reset_val_in;
endmodule
`default_nettype wire

// ---- design/scad_decode.sv ----
// command, address and data-mask decode of a dual-bank sdram
// assumes pins come from an outside controller; burst sequencing elsewhere
//
// What this block does
// - every command, address and mask input is sampled on the rising edge.
// - row strobe, column strobe and write enable together pick the command.
// - fixed encodings for activate, read, write, precharge, stop, mode, nop.
// - activate latches the row from address bits 0 to 10.
// - read or write takes the column from low bits; top bit per width.
// - flag bit high on read or write asks for auto precharge.
// - auto precharge hits the bank named by the bank-choose input.
// - precharge with flag bit high closes both banks.
// - precharge with flag bit low closes the chosen bank, plus the other if its auto precharge ends in that cycle.
// - bank-choose low picks bank a, high picks bank b.
// - read mask high disables data outputs two cycles later.
// - write mask acts at once, blocking data sampled on that edge.
`default_nettype none
module scad_decode
  import scad_pkg::*;
#(
  parameter scad_org_e ORG = ORG_X16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic device_select_n_in,
  input wire logic row_strobe_n_in,
  input wire logic col_strobe_n_in,
  input wire logic write_en_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic precharge_flag_bit_in,
  input wire logic bank_choose_in,
  input wire logic lower_byte_mask_in,
  input wire logic upper_byte_mask_in,
  input wire logic [DATA_W-1:0] data_lines_in,
  input wire logic burst_end_in,
  input wire logic read_active_in,
  input wire logic write_active_in,
  output logic [3:0] cmd_out,
  output logic activate_out,
  output logic read_out,
  output logic write_out,
  output logic [ROW_W-1:0] row_out,
  output logic [ADDR_W-1:0] column_out,
  output logic bank_out,
  output logic auto_precharge_out,
  output logic precharge_a_out,
  output logic precharge_b_out,
  output logic [LANES-1:0] dq_oe_out,
  output logic [LANES-1:0] write_byte_en_out,
  output logic [DATA_W-1:0] write_data_out
);

  typedef struct packed {
    scad_cmd_e cmd;
    logic act;
    logic rd;
    logic wr;
    logic [ROW_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic bank;
    logic auto_pre;
    logic pre_a;
    logic pre_b;
    logic pend_a;
    logic pend_b;
    logic [LANES-1:0] oe_pipe;
    logic [LANES-1:0] oe;
    logic [LANES-1:0] wr_en;
    logic [DATA_W-1:0] wr_data;
  } scad_state_s;

  localparam scad_state_s RESET_STATE = '{
    cmd: CMD_DESELECT, row: RESET_ROW, oe_pipe: RESET_OE, oe: RESET_OE,
    default: '0};

  scad_pins_s raw_pins;
  scad_pins_s smp;
  scad_pins_s idle_pins;
  logic [PINS_W-1:0] smp_bits;
  scad_cmd_e cmd_now;
  scad_state_s state_reg;
  scad_state_s state_next;

  assign raw_pins = '{select_n: device_select_n_in,
    row_strobe_n: row_strobe_n_in, col_strobe_n: col_strobe_n_in,
    write_en_n: write_en_n_in, precharge_flag_bit: precharge_flag_bit_in,
    bank_choose: bank_choose_in, addr: addr_in,
    mask: {upper_byte_mask_in, lower_byte_mask_in},
    data_lines: data_lines_in};

  // idle pins: deselected, masks high, so nothing fires right after reset
  assign idle_pins = '{select_n: 1'b1, row_strobe_n: 1'b1,
    col_strobe_n: 1'b1, write_en_n: 1'b1, mask: {LANES{1'b1}},
    default: '0};

  scad_sync #(.W(PINS_W)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in(raw_pins),
    .reset_val_in(idle_pins),
    .sync_out(smp_bits)
  );

  assign smp = scad_pins_s'(smp_bits);
  assign cmd_now = scad_decode(smp);

  always_comb begin
    state_next = state_reg;
    state_next.cmd = cmd_now;
    state_next.act = 1'b0;
    state_next.rd = 1'b0;
    state_next.wr = 1'b0;
    state_next.pre_a = 1'b0;
    state_next.pre_b = 1'b0;
    // pending auto precharge finishes even while deselected
    if (burst_end_in) begin
      state_next.pre_a = state_reg.pend_a;
      state_next.pre_b = state_reg.pend_b;
      state_next.pend_a = 1'b0;
      state_next.pend_b = 1'b0;
    end
    unique case (cmd_now)
      CMD_ACTIVATE: begin
        state_next.act = 1'b1;
        state_next.row = {smp.precharge_flag_bit, smp.addr};
        state_next.bank = smp.bank_choose;
      end
      CMD_READ, CMD_WRITE: begin
        state_next.rd = (cmd_now == CMD_READ);
        state_next.wr = (cmd_now == CMD_WRITE);
        state_next.col = smp.addr & scad_col_mask(ORG);
        state_next.bank = smp.bank_choose;
        state_next.auto_pre = smp.precharge_flag_bit;
        // a new request wins over the clear at burst end
        if (smp.precharge_flag_bit && !smp.bank_choose) begin
          state_next.pend_a = 1'b1;
        end
        if (smp.precharge_flag_bit && smp.bank_choose) begin
          state_next.pend_b = 1'b1;
        end
      end
      CMD_PRECHARGE: begin
        state_next.bank = smp.bank_choose;
        if (smp.precharge_flag_bit) begin
          state_next.pre_a = 1'b1;
          state_next.pre_b = 1'b1;
        end else if (smp.bank_choose) begin
          state_next.pre_b = 1'b1;
        end else begin
          state_next.pre_a = 1'b1;
        end
      end
      default: begin
      end
    endcase
    // read mask: first stage holds the sample, second drives the buffers
    state_next.oe_pipe = ~smp.mask;
    state_next.oe = state_reg.oe_pipe & {LANES{read_active_in}};
    // write mask gates data sampled on the same edge
    state_next.wr_en = ~smp.mask & {LANES{write_active_in}};
    state_next.wr_data = smp.data_lines;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cmd_out = state_reg.cmd;
  assign activate_out = state_reg.act;
  assign read_out = state_reg.rd;
  assign write_out = state_reg.wr;
  assign row_out = state_reg.row;
  assign column_out = state_reg.col;
  assign bank_out = state_reg.bank;
  assign auto_precharge_out = state_reg.auto_pre;
  assign precharge_a_out = state_reg.pre_a;
  assign precharge_b_out = state_reg.pre_b;
  assign dq_oe_out = state_reg.oe;
  assign write_byte_en_out = state_reg.wr_en;
  assign write_data_out = state_reg.wr_data;

  property p_cmd_sampled;
    @(posedge clk_in) disable iff (!rst_n_in)
      1'b1 |=> cmd_out == 4'($past(scad_decode(smp)));
  endproperty
  a_cmd_sampled: assert property (p_cmd_sampled)
    else $error("command output does not match sampled pins");

  property p_deselect_ignored;
    @(posedge clk_in) disable iff (!rst_n_in)
      smp.select_n |=> !activate_out && !read_out && !write_out;
  endproperty
  a_deselect_ignored: assert property (p_deselect_ignored)
    else $error("command taken while deselected");

  property p_row_latch;
    @(posedge clk_in) disable iff (!rst_n_in)
      cmd_now == CMD_ACTIVATE |=> activate_out &&
        row_out == $past({smp.precharge_flag_bit, smp.addr}) &&
        bank_out == $past(smp.bank_choose);
  endproperty
  a_row_latch: assert property (p_row_latch)
    else $error("row or bank not latched on activate");

  property p_column;
    @(posedge clk_in) disable iff (!rst_n_in)
      cmd_now inside {CMD_READ, CMD_WRITE} |=>
        column_out == ($past(smp.addr) & scad_col_mask(ORG)) &&
        auto_precharge_out == $past(smp.precharge_flag_bit);
  endproperty
  a_column: assert property (p_column)
    else $error("column or auto precharge flag wrong");

  property p_auto_bank;
    @(posedge clk_in) disable iff (!rst_n_in)
      cmd_now inside {CMD_READ, CMD_WRITE} && smp.precharge_flag_bit &&
      smp.bank_choose ##1 burst_end_in |=> precharge_b_out;
  endproperty
  a_auto_bank: assert property (p_auto_bank)
    else $error("auto precharge missed bank b");

  property p_pre_all;
    @(posedge clk_in) disable iff (!rst_n_in)
      cmd_now == CMD_PRECHARGE && smp.precharge_flag_bit |=>
        precharge_a_out && precharge_b_out;
  endproperty
  a_pre_all: assert property (p_pre_all)
    else $error("precharge all did not close both banks");

  property p_pre_one;
    @(posedge clk_in) disable iff (!rst_n_in)
      cmd_now == CMD_PRECHARGE && !smp.precharge_flag_bit &&
      !smp.bank_choose && !(burst_end_in && state_reg.pend_b) |=>
        precharge_a_out && !precharge_b_out;
  endproperty
  a_pre_one: assert property (p_pre_one)
    else $error("single precharge closed wrong bank");

  property p_read_mask;
    @(posedge clk_in) disable iff (!rst_n_in)
      smp.mask[0] |-> ##2 !dq_oe_out[0];
  endproperty
  a_read_mask: assert property (p_read_mask)
    else $error("output not disabled two cycles after mask");

  property p_read_unmask;
    @(posedge clk_in) disable iff (!rst_n_in)
      !smp.mask[1] ##1 read_active_in |=> dq_oe_out[1];
  endproperty
  a_read_unmask: assert property (p_read_unmask)
    else $error("output not enabled with mask low");

  property p_write_mask;
    @(posedge clk_in) disable iff (!rst_n_in)
      write_active_in |=> write_byte_en_out == $past(~smp.mask) &&
        write_data_out == $past(smp.data_lines);
  endproperty
  a_write_mask: assert property (p_write_mask)
    else $error("write mask not applied on same edge");

  c_activate: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    activate_out ##[1:8] read_out);
  c_auto_pre: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    write_out && auto_precharge_out ##[1:20] precharge_a_out);
  c_read_mask: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    dq_oe_out[0] ##1 !dq_oe_out[0]);

endmodule
`default_nettype wire

// ---- sim/scad_ctrl_model.sv ----
// memory controller model: drives command, address, mask and data pins
// assumes the bench calls its tasks from one process only
`default_nettype none
module scad_ctrl_model
  import scad_pkg::*;
(
  input wire logic clk_in,
  output var scad_pins_s pins_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    pins_out = '0;
    pins_out.select_n = 1'b1;
    pins_out.row_strobe_n = 1'b1;
    pins_out.col_strobe_n = 1'b1;
    pins_out.write_en_n = 1'b1;
    pins_out.mask = 2'h3;
  end

  // one command cycle, then nop with address lines showing junk
  task automatic send(input logic [3:0] c, input logic [ROW_W-1:0] a,
                      input logic b);
    @(posedge clk_in);
    pins_out.select_n <= c[3];
    pins_out.row_strobe_n <= c[2];
    pins_out.col_strobe_n <= c[1];
    pins_out.write_en_n <= c[0];
    pins_out.addr <= a[ADDR_W-1:0];
    pins_out.precharge_flag_bit <= a[FLAG_POS];
    pins_out.bank_choose <= b;
    @(posedge clk_in);
    pins_out.select_n <= 1'b0;
    pins_out.row_strobe_n <= 1'b1;
    pins_out.col_strobe_n <= 1'b1;
    pins_out.write_en_n <= 1'b1;
    pins_out.addr <= ~a[ADDR_W-1:0];
    pins_out.precharge_flag_bit <= ~a[FLAG_POS];
    pins_out.bank_choose <= ~b;
  endtask

  task automatic set_mask(input logic [1:0] m, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    pins_out.mask <= m;
    pins_out.data_lines <= d;
  endtask
endmodule
`default_nettype wire

// ---- sim/sdram_command_address_decode_tb.sv ----
// self-checking bench for the command, address and mask decode
// assumes the x16 organisation and the controller model beside it
`default_nettype none
module sdram_command_address_decode_tb;
  import scad_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic burst_end = 1'b0;
  logic rd_act = 1'b0;
  logic wr_act = 1'b0;
  scad_pins_s pins;
  logic [3:0] cmd;
  logic act, rd, wr, ap, pa, pb;
  logic [ROW_W-1:0] row;
  logic [ADDR_W-1:0] col;
  logic bank;
  logic [LANES-1:0] oe, ben;
  logic [DATA_W-1:0] wdata;
  logic [4:0] pulses;
  int n_errors = 0;
  int tests_run = 0;

  assign pulses = {act, rd, wr, pa, pb};

  initial begin
    forever #20 clk_in = ~clk_in;
  end

  scad_ctrl_model u_scad_ctrl_model (.clk_in(clk_in), .pins_out(pins));

  scad_decode #(.ORG(ORG_X16)) u_scad_decode (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .device_select_n_in(pins.select_n),
    .row_strobe_n_in(pins.row_strobe_n),
    .col_strobe_n_in(pins.col_strobe_n),
    .write_en_n_in(pins.write_en_n), .addr_in(pins.addr),
    .precharge_flag_bit_in(pins.precharge_flag_bit),
    .bank_choose_in(pins.bank_choose),
    .lower_byte_mask_in(pins.mask[0]), .upper_byte_mask_in(pins.mask[1]),
    .data_lines_in(pins.data_lines), .burst_end_in(burst_end),
    .read_active_in(rd_act), .write_active_in(wr_act), .cmd_out(cmd),
    .activate_out(act), .read_out(rd), .write_out(wr), .row_out(row),
    .column_out(col), .bank_out(bank), .auto_precharge_out(ap),
    .precharge_a_out(pa), .precharge_b_out(pb), .dq_oe_out(oe),
    .write_byte_en_out(ben), .write_data_out(wdata));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      n_errors++;
    end
  endtask

  // bit index: 4 activate, 3 read, 2 write, 1 bank a close, 0 bank b close
  task automatic wait_p(input int i);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_in);
      #1;
      if (pulses[i] === 1'b1) begin
        return;
      end
    end
    $display("mismatch pulse %0d expected 1 seen 0", i);
    n_errors++;
    complete_run();
  endtask

  task automatic t_codes();
    logic [3:0] enc [9] = '{4'h3, 4'h5, 4'h4, 4'h2, 4'h6, 4'h0, 4'h1, 4'hf,
                            4'h7};
    scad_cmd_e ex [9] = '{CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
                          CMD_BURST_STOP, CMD_MODE_SET, CMD_REFRESH,
                          CMD_DESELECT, CMD_NOP};
    for (int i = 0; i < 9; i++) begin
      u_scad_ctrl_model.send(enc[i], 11'h000, 1'b0);
      // decoded code stands for one cycle, three edges after the drive edge
      repeat (2) @(posedge clk_in);
      #1;
      chk("cmd", {12'h000, 4'(ex[i])}, {12'h000, cmd});
    end
    $display("test codes done");
  endtask

  task automatic t_activate();
    u_scad_ctrl_model.send(4'h3, 11'h5a3, 1'b1);
    wait_p(4);
    chk("row", 16'h05a3, {5'h00, row});
    chk("bank", 16'h0001, {15'h0000, bank});
    $display("test activate done");
  endtask

  task automatic t_read_auto();
    u_scad_ctrl_model.send(4'h5, 11'h7a5, 1'b1);
    wait_p(3);
    chk("column", 16'h00a5, {6'h00, col});
    chk("auto", 16'h0001, {15'h0000, ap});
    @(posedge clk_in);
    burst_end <= 1'b1;
    @(posedge clk_in);
    burst_end <= 1'b0;
    #1;
    chk("close b", 16'h0001, {15'h0000, pb});
    chk("close a", 16'h0000, {15'h0000, pa});
    $display("test read auto done");
  endtask

  task automatic t_precharge();
    u_scad_ctrl_model.send(4'h2, 11'h400, 1'b0);
    wait_p(1);
    chk("close b", 16'h0001, {15'h0000, pb});
    u_scad_ctrl_model.send(4'h2, 11'h000, 1'b1);
    wait_p(0);
    chk("close a", 16'h0000, {15'h0000, pa});
    $display("test precharge done");
  endtask

  task automatic t_deselect();
    logic seen;
    u_scad_ctrl_model.send(4'h4, 11'h433, 1'b0);
    wait_p(2);
    u_scad_ctrl_model.send(4'hb, 11'h123, 1'b0);
    // burst ends in the very cycle the deselect is decoded
    @(posedge clk_in);
    burst_end <= 1'b1;
    @(posedge clk_in);
    burst_end <= 1'b0;
    #1;
    chk("close a idle", 16'h0001, {15'h0000, pa});
    seen = act | rd | wr;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in);
      #1;
      seen = seen | act | rd | wr;
    end
    chk("ignored", 16'h0000, {15'h0000, seen});
    $display("test deselect done");
  endtask

  task automatic t_write();
    u_scad_ctrl_model.send(4'h4, 11'h012, 1'b0);
    wait_p(2);
    chk("auto off", 16'h0000, {15'h0000, ap});
    u_scad_ctrl_model.set_mask(2'h1, 16'hbeef);
    // write beat must meet the mask in the cycle it leaves the synchroniser
    repeat (2) @(posedge clk_in);
    wr_act <= 1'b1;
    @(posedge clk_in);
    wr_act <= 1'b0;
    #1;
    chk("byte en", 16'h0002, {14'h0000, ben});
    chk("wdata", 16'hbeef, wdata);
    $display("test write done");
  endtask

  task automatic t_read_mask();
    u_scad_ctrl_model.set_mask(2'h0, 16'h0000);
    rd_act <= 1'b1;
    repeat (6) @(posedge clk_in);
    u_scad_ctrl_model.set_mask(2'h2, 16'h0000);
    repeat (3) @(posedge clk_in);
    #1;
    chk("oe early", 16'h0003, {14'h0000, oe});
    @(posedge clk_in);
    #1;
    chk("oe off", 16'h0001, {14'h0000, oe});
    rd_act <= 1'b0;
    $display("test read mask done");
  endtask

  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    t_codes();
    t_activate();
    t_read_auto();
    t_precharge();
    t_deselect();
    t_write();
    t_read_mask();
    complete_run();
  end
endmodule
`default_nettype wire
